// ===== src/irt_consts.vh
`ifndef IRT_CONSTS_VH
`define IRT_CONSTS_VH

// pin control register layout and reset value
`define IRT_PCR_RESET       8'h26
`define IRT_PCR_FIRST_MODE  0
`define IRT_PCR_KSCAN_MODE  1
`define IRT_PCR_IND_MODE    2
`define IRT_PCR_STOP_WAKE   3
`define IRT_PCR_SENSE_PD    4
`define IRT_PCR_KEY_PD      5
`define IRT_PCR_WMASK       8'h3f

// timer word and high modulo register layout
`define IRT_TW_OE_BIT       9
`define IRT_MOD_SEL_BIT     9

// register selectors on the cpu register port
`define IRT_SEL_TIMER       2'h0
`define IRT_SEL_MOD_LOW     2'h1
`define IRT_SEL_MOD_HIGH    2'h2
`define IRT_SEL_PCR         2'h3

// timing: one count every 64 system-clock periods
`define IRT_PRESCALE        64
`define IRT_NORMAL_TRIM     6'h04
`define IRT_FAST_TRIM       6'h02
`define IRT_MOD_RESET       10'h001

`endif

// ===== src/irt_timer_carrier.v
`timescale 1ns/1ps
`default_nettype none
`include "irt_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - loading a nonzero count starts the down counter; zero leaves it stopped
// - running counter decrements once every 64 system clocks
// - at zero the timer stops and end signal holds while stopped
// - end signal releases a timer halt wait
// - normal timing interval is (n+1)*64 minus 4 clocks
// - fast timing interval is (n+0.5)*64 minus 2 clocks
// - back to back loads trim the total only once
// - with output enabled indicator low and transmit high while running
// - carrier replaces steady high when carrier select bit is zero
// - carrier uses one 9-bit counter and two modulo registers
// - bit 9 of the low period register reads zero
// - carrier counter advances at twice the system clock
// - each phase lasts modulo value plus one doubled-clock periods
// - modulo registers support nibble access and full loads, 10 bits in the high one and 9 in the low one
// - pin control register is 8 bits, resets to 26h, top bits zero
// - bit 0 selects first sense input off or input mode
// - bit 1 key scan direction, bit 2 indicator input or timer output
// - bit 3 enables stop wake from third sense input with pull-down
// - bit 4 sense and indicator pull-downs, bit 5 key input pull-downs
// - pull-downs drop for pins in output or off mode
// - transmit low when count zero or output disabled unless a high phase is ending, else carrier or high
// - carrier starts low; an ending high phase completes before going low
module irt_timer_carrier
(
  input  wire        i_mclk,
  input  wire        i_rst,
  input  wire        i_fast_mode,
  input  wire        i_wr,
  input  wire        i_rd_halt_wait,
  input  wire [1:0]  i_sel,
  input  wire        i_nib_wr,
  input  wire [1:0]  i_nib_idx,
  input  wire [9:0]  i_wdata,
  input  wire [1:0]  i_rsel,
  input  wire [1:0]  i_rnib_idx,
  output wire [9:0]  o_rdata,
  output wire [3:0]  o_rnib,
  output wire        o_timer_end,
  output wire        o_halt_release,
  output reg         o_transmit_pin,
  output reg         o_indicator_pin_out,
  output wire        o_indicator_pin_oe_n,
  output wire        o_first_sense_enable,
  output wire        o_key_scan_oe_n,
  output wire        o_first_sense_pd,
  output wire        o_indicator_pd,
  output wire        o_third_sense_pd,
  output wire        o_third_sense_wake_en,
  output wire        o_key_input_pd
);

  localparam [5:0] PRE_LAST   = 6'h3f;
  localparam [5:0] TRIM_NORM  = `IRT_NORMAL_TRIM;
  localparam [5:0] TRIM_FAST  = `IRT_FAST_TRIM;
  localparam [5:0] HALF_PRE   = 6'h20;

  // carrier phase states, one-hot
  localparam [2:0] CS_IDLE = 3'b001;
  localparam [2:0] CS_LOW  = 3'b010;
  localparam [2:0] CS_HIGH = 3'b100;

  reg [8:0] count_q;
  reg       oe_q;
  reg [5:0] pre_q;
  reg [9:0] mod_low_q;
  reg [9:0] mod_high_q;
  reg [7:0] pcr_q;
  reg [8:0] car_cnt_q;
  reg [2:0] car_st_q;
  reg [9:0] rdata_r;
  reg       first_q;    // first prescale wrap after a load is still pending

  ////////////////////////////////////////////////////////////////////////////////
  // helper functions shared by the register port and the carrier generator

  // write strobe decode for one register selector
  function sel_hit;
    input       wr;
    input [1:0] sel;
    input [1:0] code;
    begin
      sel_hit = wr && (sel == code);
    end
  endfunction

  // next phase length in half-clock ticks; an even residue from the phase
  // that just ended carries one doubled-clock tick into the new phase
  function [8:0] phase_reload;
    input [8:0] modv;
    input       odd_left;
    begin
      phase_reload = modv - {8'h00, !odd_left};
    end
  endfunction

  // nibble merge for 4-bit partial writes
  function [9:0] nib_merge;
    input [9:0] old;
    input [1:0] idx;
    input [3:0] nib;
    begin
      nib_merge = old;
      case (idx)
        2'h0: nib_merge[3:0] = nib;
        2'h1: nib_merge[7:4] = nib;
        2'h2: nib_merge[9:8] = nib[1:0];
        default: nib_merge = old;
      endcase
    end
  endfunction

  // nibble extract for 4-bit partial reads
  function [3:0] nib_get;
    input [9:0] val;
    input [1:0] idx;
    begin
      case (idx)
        2'h0: nib_get = val[3:0];
        2'h1: nib_get = val[7:4];
        2'h2: nib_get = {2'h0, val[9:8]};
        default: nib_get = 4'h0;
      endcase
    end
  endfunction

  // register write decode; one strobe per register
  wire       wr_timer = sel_hit(i_wr, i_sel, `IRT_SEL_TIMER);
  wire       wr_low   = sel_hit(i_wr, i_sel, `IRT_SEL_MOD_LOW);
  wire       wr_high  = sel_hit(i_wr, i_sel, `IRT_SEL_MOD_HIGH);
  wire       wr_pcr   = sel_hit(i_wr, i_sel, `IRT_SEL_PCR);
  wire [9:0] tw_cur   = {oe_q, count_q};
  wire [9:0] tw_new   = i_nib_wr ? nib_merge(tw_cur, i_nib_idx, i_wdata[3:0]) : i_wdata;
  wire       running  = (count_q != 9'h000);

  ////////////////////////////////////////////////////////////////////////////////
  // down counter, prescaler and output enable
  // a load onto a stopped counter restarts the prescale phase with the trim taken, a load while running keeps it, so the
  // first period is short by the trim and later back-to-back loads are full
  // the first wrap after any load is swallowed, so a count of n runs for
  // n+1 prescale periods before the zero detector fires
  wire       pre_wrap = (pre_q == PRE_LAST);

  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count_q <= 9'h000;
      oe_q    <= 1'b0;
      pre_q   <= 6'h00;
      first_q <= 1'b0;
    end
    else if (wr_timer)
    begin
      oe_q    <= tw_new[`IRT_TW_OE_BIT];
      count_q <= tw_new[8:0];
      first_q <= 1'b1;
      if (running)
        pre_q <= pre_q;
      else if (i_fast_mode)
        pre_q <= HALF_PRE + TRIM_FAST;
      else
        pre_q <= TRIM_NORM;
    end
    else if (running)
    begin
      pre_q <= pre_q + 6'h01;
      if (pre_wrap)
      begin
        if (first_q)
          first_q <= 1'b0;
        else
          count_q <= count_q - 9'h001;
      end
    end
  end

  // zero detector drives end signal and halt release
  assign o_timer_end    = !running;
  assign o_halt_release = i_rd_halt_wait && !running;

  ////////////////////////////////////////////////////////////////////////////////
  // modulo registers and pin control register
  // the low period register never stores bit 9, so a stray carrier select
  // written there cannot be read back or reach the carrier
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mod_low_q  <= `IRT_MOD_RESET;
      mod_high_q <= `IRT_MOD_RESET;
      pcr_q      <= `IRT_PCR_RESET;
    end
    else
    begin
      if (wr_low)
      begin
        mod_low_q <= (i_nib_wr ? nib_merge(mod_low_q, i_nib_idx, i_wdata[3:0]) : i_wdata) & 10'h1ff;
      end
      if (wr_high)
        mod_high_q <= i_nib_wr ? nib_merge(mod_high_q, i_nib_idx, i_wdata[3:0]) : i_wdata;
      if (wr_pcr)
        pcr_q <= i_wdata[7:0] & `IRT_PCR_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // carrier generator: counts two ticks per system clock to model the doubled clock
  // each phase lasts (mod+1) doubled-clock periods, i.e. (mod+1)/2 system clocks
  // odd phase lengths end half way through a system clock; the leftover tick
  // is handed to the next phase so the long-run period stays exact
  // a high phase always runs to its end, even once the timer has stopped
  wire       car_on   = running && oe_q && !mod_high_q[`IRT_MOD_SEL_BIT];
  wire [8:0] car_dec  = (car_cnt_q > 9'h001) ? car_cnt_q - 9'h002 : 9'h000;
  wire       car_done = (car_cnt_q <= 9'h001);

  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      car_st_q  <= CS_IDLE;
      car_cnt_q <= 9'h000;
    end
    else
    begin
      case (car_st_q)
        CS_IDLE:
        begin
          if (car_on)
          begin
            car_st_q  <= CS_LOW;
            car_cnt_q <= mod_low_q[8:0];
          end
        end
        CS_LOW:
        begin
          if (!car_on)
            car_st_q <= CS_IDLE;
          else if (car_done)
          begin
            car_st_q  <= CS_HIGH;
            car_cnt_q <= phase_reload(mod_high_q[8:0], car_cnt_q[0]);
          end
          else
            car_cnt_q <= car_dec;
        end
        CS_HIGH:
        begin
          if (car_done)
          begin
            car_st_q  <= car_on ? CS_LOW : CS_IDLE;
            car_cnt_q <= phase_reload(mod_low_q[8:0], car_cnt_q[0]);
          end
          else
            car_cnt_q <= car_dec;
        end
        default:
        begin
          car_st_q  <= CS_IDLE;
          car_cnt_q <= 9'h000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output pins, registered
  // the high phase test comes first so a frame that ends mid-pulse keeps the
  // pulse at full width; the indicator follows the running state and output enable only
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_transmit_pin      <= 1'b0;
      o_indicator_pin_out <= 1'b1;
    end
    else
    begin
      if (car_st_q == CS_HIGH)
        o_transmit_pin <= 1'b1;
      else if (!running || !oe_q)
        o_transmit_pin <= 1'b0;
      else if (mod_high_q[`IRT_MOD_SEL_BIT])
        o_transmit_pin <= 1'b1;
      else
        o_transmit_pin <= 1'b0;
      o_indicator_pin_out <= !(oe_q && running);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin modes and pull-down switching
  // decoded pin modes; a pin that is driven or off never keeps a pull-down
  wire first_in_mode  = pcr_q[`IRT_PCR_FIRST_MODE];
  wire kscan_out_mode = pcr_q[`IRT_PCR_KSCAN_MODE];
  wire ind_out_mode   = pcr_q[`IRT_PCR_IND_MODE];
  wire stop_wake_on   = pcr_q[`IRT_PCR_STOP_WAKE];
  wire sense_pd_on    = pcr_q[`IRT_PCR_SENSE_PD];
  wire key_pd_on      = pcr_q[`IRT_PCR_KEY_PD];

  assign o_indicator_pin_oe_n  = !ind_out_mode;
  assign o_key_scan_oe_n       = !kscan_out_mode;
  assign o_first_sense_enable  = first_in_mode;
  assign o_third_sense_wake_en = stop_wake_on;
  assign o_third_sense_pd      = stop_wake_on;
  assign o_first_sense_pd      = sense_pd_on && first_in_mode;
  assign o_indicator_pd        = sense_pd_on && !ind_out_mode;
  assign o_key_input_pd        = key_pd_on;

  ////////////////////////////////////////////////////////////////////////////////
  // register read mux
  // reads are combinational so an accumulator move sees the value at once;
  // the timer word shows the live count together with the output enable
  always @*
  begin
    case (i_rsel)
      `IRT_SEL_TIMER:    rdata_r = tw_cur;
      `IRT_SEL_MOD_LOW:  rdata_r = mod_low_q;
      `IRT_SEL_MOD_HIGH: rdata_r = mod_high_q;
      `IRT_SEL_PCR:      rdata_r = {2'h0, pcr_q};
      default:           rdata_r = 10'h000;
    endcase
  end

  assign o_rdata = rdata_r;
  assign o_rnib  = nib_get(rdata_r, i_rnib_idx);

endmodule // irt_timer_carrier

`default_nettype wire

// ===== tb/irt_led.sv
`timescale 1ns/1ps
`default_nettype none
// diode pair on the transmit and indicator pins
module irt_led
(
  input  wire logic        i_mclk,
  input  wire logic        i_tx,
  input  wire logic        i_ind,
  input  wire logic        i_oe_n,
  output logic             o_done,
  output logic [15:0]      o_len,
  output logic [15:0]      o_edges
);
  logic lit_q = 0;
  logic tx_q = 0;
  // led only lights while the pin sinks current
  wire logic lit = !i_oe_n && i_ind === 1'b0;
  // lit time and transmit pulses per frame
  always @(posedge i_mclk)
  begin
    o_done <= lit_q && !lit;
    lit_q <= lit;
    tx_q <= i_tx;
    if (lit && !lit_q)
      o_len <= 16'd1;
    else if (lit)
      o_len <= o_len + 16'd1;
    if (lit && !lit_q)
      o_edges <= {15'd0, i_tx && !tx_q};
    else if (lit && i_tx && !tx_q)
      o_edges <= o_edges + 16'd1;
  end
endmodule // irt_led
`default_nettype wire

// ===== tb/irt_sva.sv
`timescale 1ns/1ps
`default_nettype none
// timer status and pin control relations
module irt_sva
(
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_wr,
  input wire logic [1:0] i_sel,
  input wire logic [9:0] i_wdata,
  input wire logic       i_rd_halt_wait,
  input wire logic [1:0] i_rsel,
  input wire logic [9:0] o_rdata,
  input wire logic       o_timer_end,
  input wire logic       o_halt_release,
  input wire logic       o_indicator_pin_out,
  input wire logic       o_indicator_pd,
  input wire logic       o_indicator_pin_oe_n,
  input wire logic       o_third_sense_pd,
  input wire logic       o_third_sense_wake_en
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // timer word write strobe
  wire logic ld = i_wr && i_sel == 2'h0;
  property p_zero; ld && i_wdata[8:0] == 9'h0 |=> o_timer_end; endproperty
  a_zero: assert property (p_zero) else $error("zero load started timer");
  property p_run; ld && i_wdata[8:0] != 9'h0 |=> !o_timer_end [*8]; endproperty
  a_run: assert property (p_run) else $error("timer ended too soon");
  property p_hold; o_timer_end && !ld |=> o_timer_end; endproperty
  a_hold: assert property (p_hold) else $error("end signal dropped");
  property p_halt; o_halt_release == (i_rd_halt_wait && o_timer_end); endproperty
  a_halt: assert property (p_halt) else $error("halt release wrong");
  property p_ind_on; ld && i_wdata[9] && i_wdata[8:0] != 9'h0 |=> ##1 !o_indicator_pin_out; endproperty
  a_ind_on: assert property (p_ind_on) else $error("indicator not low");
  property p_ind_off; o_timer_end |=> o_indicator_pin_out; endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicator not high");
  property p_lowb9; i_rsel == 2'h1 |-> !o_rdata[9]; endproperty
  a_lowb9: assert property (p_lowb9) else $error("low period bit 9 set");
  property p_pd; o_indicator_pd |-> o_indicator_pin_oe_n; endproperty
  a_pd: assert property (p_pd) else $error("pull-down on driven pin");
  property p_wake; o_third_sense_pd == o_third_sense_wake_en; endproperty
  a_wake: assert property (p_wake) else $error("wake pull-down mismatch");
  c_halt: cover property (i_rd_halt_wait && o_halt_release);
  c_start: cover property (ld && i_wdata[9]);
  c_end: cover property ($rose(o_timer_end));
endmodule // irt_sva
`default_nettype wire

// ===== tb/tb_irt_timer_carrier.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_irt_timer_carrier;
  logic i_mclk = 0, i_rst = 1, i_fast_mode = 0, i_wr = 0, i_rd_halt_wait = 0, i_nib_wr = 0;
  logic [1:0] i_sel = 0, i_nib_idx = 0, i_rsel = 0, i_rnib_idx = 0;
  logic [9:0] i_wdata = 0;
  wire [9:0] o_rdata;
  wire [3:0] o_rnib;
  wire o_timer_end, o_halt_release, o_transmit_pin, o_indicator_pin_out, o_indicator_pin_oe_n;
  wire o_first_sense_enable, o_key_scan_oe_n, o_first_sense_pd, o_indicator_pd;
  wire o_third_sense_pd, o_third_sense_wake_en, o_key_input_pd, done;
  wire [15:0] len, edges;
  logic [31:0] seed = 32'he261c52b, r, ex;
  logic [31:0] q[$];
  int miscompares = 0, comparisons = 0;
  irt_timer_carrier i_irt_timer_carrier (.*);
  irt_led i_irt_led (.i_mclk(i_mclk), .i_tx(o_transmit_pin), .i_ind(o_indicator_pin_out),
    .i_oe_n(o_indicator_pin_oe_n), .o_done(done), .o_len(len), .o_edges(edges));
  always #5 i_mclk = ~i_mclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [1:0] s, input logic [9:0] d, input logic n = 0, input logic [1:0] x = 0);
    i_wr = 1;
    i_sel = s;
    i_wdata = d;
    i_nib_wr = n;
    i_nib_idx = x;
    @(negedge i_mclk);
    i_wr = 0;
    @(negedge i_mclk);
  endtask
  task automatic rd(input logic [1:0] s, input logic [1:0] x);
    i_rsel = s;
    i_rnib_idx = x;
    @(negedge i_mclk);
  endtask
  task automatic results();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // start an enabled count and wait for the led frame
  task automatic run(input logic [8:0] n, input logic [31:0] e);
    q.push_back(e);
    wr(2'h0, {1'b1, n});
    for (int k = 0; k < 4000 && q.size() > 0; k++)
      @(negedge i_mclk);
    if (q.size() > 0)
    begin
      miscompares++;
      results();
    end
    $display("run n=%0d ended", n);
  endtask
  // compare each reported frame with the oldest note
  always @(posedge i_mclk)
    if (done === 1'b1)
    begin
      ex = q.pop_front();
      `CHK({len, edges}, ex)
    end
  initial
  begin
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 0;
    rd(2'h3, 2'h0);
    `CHK({o_rdata, o_timer_end}, {10'h026, 1'b1})
    for (int k = 0; k < 6; k++)
    begin
      r = xs();
      wr(2'h3, r[9:0]);
      rd(2'h3, 2'h0);
      `CHK(o_rdata, {4'h0, r[5:0]})
      `CHK({o_first_sense_enable, o_key_scan_oe_n, o_indicator_pin_oe_n}, {r[0], !r[1], !r[2]})
      `CHK({o_third_sense_wake_en, o_third_sense_pd, o_key_input_pd}, {r[3], r[3], r[5]})
      `CHK({o_first_sense_pd, o_indicator_pd}, {r[4] & r[0], r[4] & !r[2]})
    end
    $display("pin control ended");
    wr(2'h3, 10'h026);
    wr(2'h1, 10'h3ff);
    rd(2'h1, 2'h0);
    `CHK(o_rdata, 10'h1ff)
    wr(2'h2, 10'h000);
    wr(2'h2, 10'h003, 1'b1, 2'h2);
    rd(2'h2, 2'h2);
    `CHK({o_rdata, o_rnib}, {10'h300, 4'h3})
    wr(2'h2, 10'h201);
    for (int k = 0; k < 3; k++)
    begin
      r = xs() % 3 + 1;
      run(r[8:0], {16'd64 * r[15:0] + 16'd60, 16'd1});
    end
    i_rd_halt_wait = 1;
    wr(2'h0, 10'h001);
    `CHK({o_halt_release, o_transmit_pin, o_indicator_pin_out}, 3'b001)
    for (int k = 0; k < 200 && o_timer_end !== 1'b1; k++)
      @(negedge i_mclk);
    `CHK(o_halt_release, 1'b1)
    i_rd_halt_wait = 0;
    wr(2'h0, 10'h200);
    `CHK({o_timer_end, o_transmit_pin}, 2'b10)
    wr(2'h1, 10'h003);
    wr(2'h2, 10'h003);
    run(9'h1, {16'd124, 16'd31});
    i_fast_mode = 1;
    i_rst = 1;
    @(negedge i_mclk);
    i_rst = 0;
    wr(2'h2, 10'h201);
    run(9'h1, {16'd94, 16'd1});
    results();
  end
endmodule // tb_irt_timer_carrier
bind irt_timer_carrier irt_sva i_irt_sva (.*);
`default_nettype wire
